// ### hdl/irq_priority_pick.sv
`timescale 1ns/100ps
`default_nettype none
module irq_priority_pick (
    input  wire logic [15:1] pending,
    input  wire logic [15:4] sourceIrqEnable,
    input  wire logic        masterIrqEnable,
    input  wire logic        ext0IrqGate,
    output var  logic        winValid,
    output var  logic [3:0]  winIndex,
    output var  logic [15:0] winVector
);
    logic [15:1] eligible;

    // Per-level acceptance condition
    for (genvar i = 1; i < 16; i++) begin : g_elig
        if (i < rst_irq_pkg::FIRST_MASKABLE) begin : g_nmi
            assign eligible[i] = pending[i];
        end else if (i == rst_irq_pkg::EXT0_LATCH) begin : g_ext0
            assign eligible[i] = pending[i] & masterIrqEnable
                                 & sourceIrqEnable[i] & ext0IrqGate;
        end else begin : g_mask
            assign eligible[i] = pending[i] & masterIrqEnable
                                 & sourceIrqEnable[i];
        end
    end

    // Lowest index is highest priority; non-maskables tie, lowest just wins
    always_comb begin
        winIndex = 4'h0;
        for (int i = 15; i >= 1; i--) begin
            if (eligible[i]) begin
                winIndex = 4'(i);
            end
        end
        winValid = |eligible;
        // Vector steps down two bytes per level from the reset vector
        winVector = rst_irq_pkg::RESET_VECTOR
                    - {11'h000, winIndex, 1'b0};
    end
endmodule
`default_nettype wire

// ### hdl/malfunction_reset_stretch.sv
`timescale 1ns/100ps
`default_nettype none
module malfunction_reset_stretch #(
    parameter int unsigned CYCLES = rst_irq_pkg::MALF_RESET_CYCLES
) (
    input  wire logic clk,
    input  wire logic rstAsync_b,
    input  wire logic trigger,
    output var  logic active
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);

    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;

    // Reload on every fault so the pulse never runs past CYCLES after the last
    always_comb begin
        if (trigger) begin
            count_d = LOAD;
        end else if (count_q != '0) begin
            count_d = count_q - CW'(1);
        end else begin
            count_d = '0;
        end
    end

    // Power-up loads a full count: one spurious pulse is possible by design
    always_ff @(posedge clk or negedge rstAsync_b) begin
        if (!rstAsync_b) begin
            count_q <= LOAD;
        end else begin
            count_q <= count_d;
        end
    end

    assign active = (count_q != '0);

    chk_stretch_end : assert property (@(posedge clk) disable iff (!rstAsync_b)
        (count_q == CW'(1) && !trigger) |=> !active)
        else $error("Malfunction reset outlived its count");
endmodule
`default_nettype wire

// ### hdl/reset_and_interrupt_control.sv
`timescale 1ns/100ps
`default_nettype none
module reset_and_interrupt_control #(
    parameter logic [15:0] SFA_FIRST = rst_irq_pkg::SFA_FIRST,
    parameter logic [15:0] SFA_LAST  = rst_irq_pkg::SFA_LAST,
    parameter logic [15:0] RAM_FIRST = rst_irq_pkg::RAM_FIRST,
    parameter logic [15:0] RAM_LAST  = rst_irq_pkg::RAM_LAST,
    parameter logic [15:0] BUF_FIRST = rst_irq_pkg::BUF_FIRST,
    parameter logic [15:0] BUF_LAST  = rst_irq_pkg::BUF_LAST
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        resetPinIn,
    output var  logic        resetPinOut,
    output var  logic        resetPinOe_b,
    output var  logic        coreReset,
    input  wire logic        fetchValid,
    input  wire logic [15:0] fetchAddr,
    input  wire logic        wdtCtrlWrite,
    input  wire logic        wdtCtrlTrapArea,
    input  wire logic        wdtCtrlTrapAction,
    input  wire logic        wdtCtrlWdtAction,
    input  wire logic        wdtCtrlWdtEnable,
    output var  logic        watchdogEnable,
    input  wire logic        watchdogExpire,
    input  wire logic        fastOscOn,
    input  wire logic        slowOscOn,
    input  wire logic        clockSelect,
    input  wire logic        softwareIrq,
    input  wire logic        undefinedOpIrq,
    input  wire logic [13:4] sourceIrq,
    input  wire logic        ext4Irq,
    input  wire logic        serialTxIrq,
    input  wire logic        ext5Irq,
    input  wire logic        converterDoneIrq,
    input  wire logic        level15SourceSelect,
    input  wire logic        level16SourceSelect,
    input  wire logic [15:4] sourceIrqEnable,
    input  wire logic        ext0IrqGate,
    input  wire logic        latchClearStrobe,
    input  wire logic [15:2] latchClearMask,
    output var  logic [15:1] irqPendingLatch,
    input  wire logic        eiStrobe,
    input  wire logic        diStrobe,
    input  wire logic        retiStrobe,
    input  wire logic        retiMasterEnable,
    output var  logic        masterIrqEnable,
    output var  logic        irqRequest,
    input  wire logic        irqAccept,
    output var  logic [15:0] vectorAddr,
    output var  logic        vectorValid,
    input  wire logic        vectorFetch,
    output var  logic        stackedMasterEnable
);
    // Reset release and pin synchronisers
    logic rstMeta_q;
    logic rstN;
    logic pinMeta_q;
    logic pinSync_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_q <= 1'b0;
            rstN      <= 1'b0;
            pinMeta_q <= 1'b1;
            pinSync_q <= 1'b1;
        end else begin
            rstMeta_q <= 1'b1;
            rstN      <= rstMeta_q;
            pinMeta_q <= resetPinIn;
            pinSync_q <= pinMeta_q;
        end
    end

    // External reset qualifier: a glitch shorter than the minimum is ignored
    localparam int unsigned EW = $clog2(rst_irq_pkg::EXT_RESET_CYCLES + 1);
    localparam logic [EW-1:0] EXT_MAX = EW'(rst_irq_pkg::EXT_RESET_CYCLES);
    logic [EW-1:0] extCnt_q;
    logic [EW-1:0] extCnt_d;
    logic          extReset;

    always_comb begin
        if (pinSync_q || !resetPinOe_b) begin
            extCnt_d = '0;
        end else if (extCnt_q != EXT_MAX) begin
            extCnt_d = extCnt_q + EW'(1);
        end else begin
            extCnt_d = extCnt_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            extCnt_q <= '0;
        end else begin
            extCnt_q <= extCnt_d;
        end
    end

    assign extReset = (extCnt_q == EXT_MAX);

    // Malfunction detection
    logic trapArea_q;
    logic trapAction_q;
    logic wdtAction_q;
    logic wdtEnable_q;
    logic fastPrev_q;
    logic slowPrev_q;
    logic selPrev_q;
    logic trapHit;
    logic clockFault;
    logic malfTrigger;
    logic stretchActive;
    logic sysReset;

    always_comb begin
        trapHit = fetchValid
            && ((fetchAddr >= SFA_FIRST && fetchAddr <= SFA_LAST)
             || (fetchAddr >= BUF_FIRST && fetchAddr <= BUF_LAST)
             || (trapArea_q && fetchAddr >= RAM_FIRST
                 && fetchAddr <= RAM_LAST));
        // Only a falling enable counts; oscillators are never stopped here
        clockFault = (fastPrev_q && !fastOscOn && slowPrev_q && !slowOscOn)
            || (fastPrev_q && !fastOscOn && !selPrev_q)
            || (slowPrev_q && !slowOscOn && selPrev_q);
        malfTrigger = (trapHit && trapAction_q)
            || (watchdogExpire && wdtAction_q)
            || clockFault;
    end

    malfunction_reset_stretch #(
        .CYCLES     (rst_irq_pkg::MALF_RESET_CYCLES)
    ) u_stretch (
        .clk        (ref_clk),
        .rstAsync_b (rstN),
        .trigger    (malfTrigger),
        .active     (stretchActive)
    );

    // Own pin drive is kept out of the qualifier, so faults stay 24 long
    assign sysReset     = extReset || stretchActive;
    assign coreReset    = sysReset;
    assign resetPinOut  = 1'b0;
    assign resetPinOe_b = !stretchActive;

    // Watchdog control selects, back to reset values on any reset
    logic trapArea_d;
    logic trapAction_d;
    logic wdtAction_d;
    logic wdtEnable_d;

    always_comb begin
        trapArea_d   = trapArea_q;
        trapAction_d = trapAction_q;
        wdtAction_d  = wdtAction_q;
        wdtEnable_d  = wdtEnable_q;
        if (sysReset) begin
            trapArea_d   = rst_irq_pkg::TRAP_AREA_RST;
            trapAction_d = rst_irq_pkg::TRAP_ACTION_RST;
            wdtAction_d  = rst_irq_pkg::WDT_ACTION_RST;
            wdtEnable_d  = rst_irq_pkg::WDT_ENABLE_RST;
        end else if (wdtCtrlWrite) begin
            trapArea_d   = wdtCtrlTrapArea;
            trapAction_d = wdtCtrlTrapAction;
            wdtAction_d  = wdtCtrlWdtAction;
            wdtEnable_d  = wdtCtrlWdtEnable;
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            trapArea_q   <= rst_irq_pkg::TRAP_AREA_RST;
            trapAction_q <= rst_irq_pkg::TRAP_ACTION_RST;
            wdtAction_q  <= rst_irq_pkg::WDT_ACTION_RST;
            wdtEnable_q  <= rst_irq_pkg::WDT_ENABLE_RST;
            fastPrev_q   <= 1'b1;
            slowPrev_q   <= 1'b0;
            selPrev_q    <= 1'b0;
        end else begin
            trapArea_q   <= trapArea_d;
            trapAction_q <= trapAction_d;
            wdtAction_q  <= wdtAction_d;
            wdtEnable_q  <= wdtEnable_d;
            fastPrev_q   <= fastOscOn;
            slowPrev_q   <= slowOscOn;
            selPrev_q    <= clockSelect;
        end
    end

    assign watchdogEnable = wdtEnable_q;

    // Interrupt latches, master enable and vector hand-off
    logic [15:1] latch_q;
    logic [15:1] latch_d;
    logic [15:1] setReq;
    logic        mie_q;
    logic        mie_d;
    logic        stacked_q;
    logic        stacked_d;
    logic [15:0] vector_q;
    logic [15:0] vector_d;
    logic        hold_q;
    logic        hold_d;
    logic        winValid_q;
    logic [3:0]  winIndex_q;
    logic        sysResetPrev_q;
    logic        winValid;
    logic [3:0]  winIndex;
    logic [15:0] winVector;
    logic        accepted;

    irq_priority_pick u_pick (
        .pending         (latch_q),
        .sourceIrqEnable (sourceIrqEnable),
        .masterIrqEnable (mie_q),
        .ext0IrqGate     (ext0IrqGate),
        .winValid        (winValid),
        .winIndex        (winIndex),
        .winVector       (winVector)
    );

    assign irqRequest = winValid_q && !hold_q && !sysReset;
    assign accepted   = irqRequest && irqAccept;

    // Set beats the strobe and accept clears in the same cycle; only reset drops a request
    always_comb begin
        setReq = '0;
        setReq[rst_irq_pkg::SOFT_LEVEL] = softwareIrq || undefinedOpIrq;
        setReq[rst_irq_pkg::TRAP_LATCH] = trapHit && !trapAction_q;
        setReq[rst_irq_pkg::WDT_LATCH]  = watchdogExpire && !wdtAction_q;
        setReq[13:4] = sourceIrq;
        // Unselected shared source is not held at all
        setReq[rst_irq_pkg::SHARED15_LATCH] =
            level15SourceSelect ? serialTxIrq : ext4Irq;
        setReq[rst_irq_pkg::SHARED16_LATCH] =
            level16SourceSelect ? converterDoneIrq : ext5Irq;
        latch_d = latch_q;
        if (latchClearStrobe) begin
            latch_d[15:2] = latch_q[15:2] & ~latchClearMask;
        end
        if (accepted) begin
            latch_d[winIndex_q] = 1'b0;
        end
        latch_d = latch_d | setReq;
        if (sysReset) begin
            latch_d = '0;
        end
    end

    // Master enable, stacking and vector register
    always_comb begin
        mie_d     = mie_q;
        stacked_d = stacked_q;
        vector_d  = vector_q;
        hold_d    = hold_q;
        if (diStrobe) begin
            mie_d = 1'b0;
        end else if (eiStrobe) begin
            mie_d = 1'b1;
        end else if (retiStrobe) begin
            mie_d = retiMasterEnable;
        end
        if (vectorFetch) begin
            hold_d = 1'b0;
        end
        // Freeze on accept: the shown vector belongs to the latch cleared unless the accept comes the cycle after a fetch
        if (!hold_q && !accepted) begin
            vector_d = winVector;
        end
        if (accepted) begin
            stacked_d = mie_q;
            mie_d     = 1'b0;
            hold_d    = 1'b1;
        end
        if (sysReset) begin
            mie_d  = rst_irq_pkg::MIE_RST;
            hold_d = 1'b0;
        end else if (sysResetPrev_q) begin
            vector_d = rst_irq_pkg::RESET_VECTOR;
            hold_d   = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            latch_q        <= '0;
            mie_q          <= rst_irq_pkg::MIE_RST;
            stacked_q      <= 1'b0;
            vector_q       <= rst_irq_pkg::RESET_VECTOR;
            hold_q         <= 1'b0;
            winValid_q     <= 1'b0;
            winIndex_q     <= 4'h0;
            sysResetPrev_q <= 1'b1;
        end else begin
            latch_q        <= latch_d;
            mie_q          <= mie_d;
            stacked_q      <= stacked_d;
            vector_q       <= vector_d;
            hold_q         <= hold_d;
            winValid_q     <= winValid;
            winIndex_q     <= winIndex;
            sysResetPrev_q <= sysReset;
        end
    end

    assign irqPendingLatch     = latch_q;
    assign masterIrqEnable     = mie_q;
    assign stackedMasterEnable = stacked_q;
    assign vectorAddr          = vector_q;
    assign vectorValid         = hold_q;

    // Checks
    sequence s_fault_quiet;
        (!malfTrigger) throughout (##23 1'b1);
    endsequence

    chk_malf_len_max : assert property (@(posedge ref_clk) disable iff (!rstN)
        malfTrigger ##1 s_fault_quiet |=> !stretchActive)
        else $error("Fault reset longer than 24 cycles");
    chk_malf_pin_low : assert property (@(posedge ref_clk) disable iff (!rstN)
        malfTrigger |=> (!resetPinOe_b && coreReset) [*8])
        else $error("Reset pin not pulled low on fault");
    chk_trap_resets : assert property (@(posedge ref_clk) disable iff (!rstN)
        trapHit && trapAction_q |=> stretchActive)
        else $error("Trap did not reset");
    chk_trap_latch : assert property (@(posedge ref_clk) disable iff (!rstN)
        trapHit && !trapAction_q && !sysReset |=> latch_q[2] && !coreReset)
        else $error("Trap interrupt not latched");
    chk_wdt_latch : assert property (@(posedge ref_clk) disable iff (!rstN)
        watchdogExpire && !wdtAction_q && !sysReset |=> latch_q[3])
        else $error("Watchdog interrupt not latched");
    chk_clock_fault : assert property (@(posedge ref_clk) disable iff (!rstN)
        $fell(fastOscOn) && !selPrev_q |=> stretchActive)
        else $error("Clock fault did not reset");
    chk_imf_reset : assert property (@(posedge ref_clk) disable iff (!rstN)
        coreReset |=> !masterIrqEnable)
        else $error("Master enable survived reset");
    chk_accept_stack : assert property (@(posedge ref_clk) disable iff (!rstN)
        accepted && !sysReset |=> !mie_q
            && stacked_q == $past(mie_q) && vectorValid)
        else $error("Acceptance did not stack master enable");
    chk_vector_hold : assert property (@(posedge ref_clk) disable iff (!rstN)
        accepted ##1 (!vectorFetch && !sysReset) |=> $stable(vectorAddr))
        else $error("Vector changed before fetch");
    chk_reset_vector : assert property (@(posedge ref_clk) disable iff (!rstN)
        $fell(sysReset) |=> vectorAddr == rst_irq_pkg::RESET_VECTOR)
        else $error("Reset vector not presented");
endmodule
`default_nettype wire

// ### hdl/rst_irq_pkg.sv
// Operation
// - Trap, watchdog, clock faults reset for up to 24 clocks, pin driven low.
// - Fault reset logic is not cleared at power-up; one spurious pulse may follow.
// - On reset release execution starts at the vector held at FFFE/FFFF.
// - Reset clears master enable, keeps core state, and enables the watchdog.
// - Fetch from special area, buffer area or trap-selected RAM raises a trap.
// - Trap resets while trap action select is 1; at 0 it latches an interrupt.
// - Watchdog expiry resets while its select is 1; at 0 it latches an interrupt.
// - Clearing the running oscillator enable raises a clock reset.
// - Eighteen sources, four non-maskable, served by fifteen vectors.
// - A request sets its pending latch, which then asks the core for acceptance.
// - Maskable needs master and source enable; external 0 also needs its gate.
// - Non-maskable share priority 2 at FFFC, FFFA (latch 2), FFF8 (latch 3).
// - Latches 4 to 15 take priorities 5 to 16, vectors FFF6 down to FFE0.
// - Simultaneous requests are taken in fixed priority, reset FFFE first.
// - Levels 15 and 16 are each shared by two sources chosen by a select bit.
// - Accepting an interrupt clears its pending latch at once.
// - Acceptance stacks master enable and clears it; return restores it.
// - Level 15 select 0 picks external 4, 1 picks serial transmit.
package rst_irq_pkg;

    // One fast clock period is one ref_clk period
    localparam int unsigned FAST_PER_CLK       = 1;
    localparam int unsigned MALF_FAST_MAX      = 24;
    localparam int unsigned MALF_RESET_CYCLES  = MALF_FAST_MAX / FAST_PER_CLK;
    localparam int unsigned EXT_FAST_MIN       = 12;
    localparam int unsigned EXT_RESET_CYCLES   =
        (EXT_FAST_MIN + FAST_PER_CLK - 1) / FAST_PER_CLK;

    // Vectors and latch positions
    localparam logic [15:0] RESET_VECTOR   = 16'hFFFE;
    localparam int unsigned LEVELS         = 16;
    localparam int unsigned SOFT_LEVEL     = 1;
    localparam int unsigned TRAP_LATCH     = 2;
    localparam int unsigned WDT_LATCH      = 3;
    localparam int unsigned FIRST_MASKABLE = 4;
    localparam int unsigned EXT0_LATCH     = 4;
    localparam int unsigned SHARED15_LATCH = 14;
    localparam int unsigned SHARED16_LATCH = 15;

    // Trap address windows (defaults, sized to the memory map)
    localparam logic [15:0] SFA_FIRST = 16'h0000;
    localparam logic [15:0] SFA_LAST  = 16'h003F;
    localparam logic [15:0] RAM_FIRST = 16'h0040;
    localparam logic [15:0] RAM_LAST  = 16'h083F;
    localparam logic [15:0] BUF_FIRST = 16'h0F80;
    localparam logic [15:0] BUF_LAST  = 16'h0FFF;

    // Values after reset
    localparam logic TRAP_ACTION_RST = 1'b1;
    localparam logic WDT_ACTION_RST  = 1'b1;
    localparam logic TRAP_AREA_RST   = 1'b1;
    localparam logic WDT_ENABLE_RST  = 1'b1;
    localparam logic MIE_RST         = 1'b0;

endpackage

// ### testbench/core_partner.sv
`timescale 1ns/100ps
`default_nettype none
module core_partner (
    input  wire logic        clk,
    input  wire logic        irqRequest,
    input  wire logic        vectorValid,
    input  wire logic [15:0] vectorAddr,
    input  wire logic [3:0]  fetchDelay,
    output var  logic        irqAccept,
    output var  logic        vectorFetch,
    output var  logic [15:0] lastVector,
    output var  int          nFetched
);
    int waitCnt = 0;

    initial begin
        irqAccept = 1'b0;
        vectorFetch = 1'b0;
        lastVector = 16'h0000;
        nFetched = 0;
    end

    // Core side: accept only while a request shows, fetch after a delay.
    // The delay varies so a slow core also keeps the vector waiting.
    always @(posedge clk) begin
        if (vectorFetch) begin
            lastVector = vectorAddr;
            nFetched++;
        end
        #1;
        irqAccept = irqRequest;
        if (vectorFetch || !vectorValid) begin
            vectorFetch = 1'b0;
            waitCnt = 0;
        end else if (waitCnt >= fetchDelay) begin
            vectorFetch = 1'b1;
        end else begin
            waitCnt++;
        end
    end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Compare, count, and report a mismatch at once
`define CHK(what, exp, got) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end \
end
module tb_top;
    logic ref_clk = 1'b0, rst_b = 1'b0, extLow = 1'b0, seen;
    logic fetchValid = 1'b0, wdtCtrlWrite = 1'b0, watchdogExpire = 1'b0;
    logic [15:0] fetchAddr = 16'h0010;
    logic wdtCtrlTrapArea = 1'b1, wdtCtrlTrapAction = 1'b1;
    logic wdtCtrlWdtAction = 1'b1, wdtCtrlWdtEnable = 1'b1;
    logic fastOscOn = 1'b1, slowOscOn = 1'b1, clockSelect = 1'b0;
    logic softwareIrq = 1'b0, undefinedOpIrq = 1'b0, ext4Irq = 1'b0;
    logic serialTxIrq = 1'b0, ext5Irq = 1'b0, converterDoneIrq = 1'b0;
    logic [13:4] sourceIrq = 10'h000;
    logic level15SourceSelect = 1'b0, level16SourceSelect = 1'b0;
    logic [15:4] sourceIrqEnable = 12'hFFF;
    logic ext0IrqGate = 1'b1, latchClearStrobe = 1'b0;
    logic [15:2] latchClearMask = 14'h0000;
    logic eiStrobe = 1'b0, diStrobe = 1'b0, retiStrobe = 1'b0;
    logic retiMasterEnable = 1'b0;
    logic [3:0] fetchDelay = 4'h2;
    logic resetPinOut, resetPinOe_b, coreReset, watchdogEnable, irqRequest;
    logic masterIrqEnable, vectorValid, stackedMasterEnable;
    logic irqAccept, vectorFetch;
    logic [15:1] irqPendingLatch;
    logic [15:0] vectorAddr, lastVector;
    int nFetched, n0, n_fail = 0, total_checks = 0;
    // Source code per row is its index; software first
    logic [15:0] rowVec [18] = '{16'hFFFC, 16'hFFFC, 16'hFFFA, 16'hFFF8,
        16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFEE, 16'hFFEC,
        16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFE2,
        16'hFFE0, 16'hFFE0};
    // Pin has a pull-up; either party may pull it low
    wire logic resetPin = ~extLow & (resetPinOe_b | resetPinOut);

    always #12.5 ref_clk = ~ref_clk;

    reset_and_interrupt_control dut (
        .ref_clk, .rst_b, .resetPinIn(resetPin), .resetPinOut,
        .resetPinOe_b, .coreReset, .fetchValid, .fetchAddr, .wdtCtrlWrite,
        .wdtCtrlTrapArea, .wdtCtrlTrapAction, .wdtCtrlWdtAction,
        .wdtCtrlWdtEnable, .watchdogEnable, .watchdogExpire, .fastOscOn,
        .slowOscOn, .clockSelect, .softwareIrq, .undefinedOpIrq, .sourceIrq,
        .ext4Irq, .serialTxIrq, .ext5Irq, .converterDoneIrq,
        .level15SourceSelect, .level16SourceSelect, .sourceIrqEnable,
        .ext0IrqGate, .latchClearStrobe, .latchClearMask, .irqPendingLatch,
        .eiStrobe, .diStrobe, .retiStrobe, .retiMasterEnable,
        .masterIrqEnable, .irqRequest, .irqAccept, .vectorAddr, .vectorValid,
        .vectorFetch, .stackedMasterEnable
    );

    core_partner partner (
        .clk(ref_clk), .irqRequest, .vectorValid, .vectorAddr, .fetchDelay,
        .irqAccept, .vectorFetch, .lastVector, .nFetched
    );

    // Advance past edges; every strobe lasts exactly one cycle
    task automatic step(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            {fetchValid, wdtCtrlWrite, watchdogExpire, softwareIrq} = '0;
            {undefinedOpIrq, ext4Irq, serialTxIrq, ext5Irq} = '0;
            {converterDoneIrq, eiStrobe, diStrobe, retiStrobe} = '0;
            sourceIrq = '0;
            latchClearStrobe = 1'b0;
        end
    endtask

    task automatic fire(input int code);
        case (code)
            0: softwareIrq = 1'b1;
            1: undefinedOpIrq = 1'b1;
            2: fetchValid = 1'b1;
            3: watchdogExpire = 1'b1;
            14: ext4Irq = 1'b1;
            15: serialTxIrq = 1'b1;
            16: ext5Irq = 1'b1;
            17: converterDoneIrq = 1'b1;
            default: sourceIrq[code] = 1'b1;
        endcase
    endtask

    // Bounded wait for the core to read a new vector
    task automatic waitFetch(input int start);
        int k;
        k = 0;
        while (nFetched == start && k < 200) begin
            step(1);
            k++;
        end
        `CHK("vector fetch", 1'b1, nFetched != start)
    endtask

    // Measure the pin drive, then check the state left by reset
    task automatic resetRun(input string what, input bit exact);
        int n, start;
        bit ok;
        n = 0;
        start = nFetched;
        for (int w = 0; w < 3 && resetPinOe_b !== 1'b0; w++) step(1);
        while (resetPinOe_b === 1'b0 && n < 60) begin
            n++;
            step(1);
        end
        ok = exact ? n == rst_irq_pkg::MALF_FAST_MAX
                   : n inside {[1:rst_irq_pkg::MALF_FAST_MAX]};
        `CHK(what, 1'b1, ok)
        `CHK("core reset end", 1'b0, coreReset)
        waitFetch(start);
        `CHK("reset vector", 16'hFFFE, lastVector)
        `CHK("enable after reset", 1'b0, masterIrqEnable)
        `CHK("watchdog on", 1'b1, watchdogEnable)
        `CHK("latches after reset", 15'h0000, irqPendingLatch)
        $display("test %s done", what);
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; this cuts a hang
    initial begin
        #300000;
        n_fail++;
        $display("[FAIL] run time expected done seen timeout");
        conclude();
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        step(2);
        resetRun("power-up reset", 1'b0);
        fire(2);
        resetRun("trap reset", 1'b1);
        fire(3);
        resetRun("watchdog reset", 1'b1);
        // Fast off on fast clock, slow off on slow clock, both off
        for (int c = 0; c < 3; c++) begin
            clockSelect = (c == 1);
            step(1);
            fastOscOn = (c == 1);
            slowOscOn = (c == 0);
            resetRun("clock reset", 1'b1);
            {fastOscOn, slowOscOn} = 2'b11;
        end
        // A pin pulse shorter than the minimum must not reset
        seen = 1'b0;
        extLow = 1'b1;
        for (int i = 0; i < 24; i++) begin
            if (i == 8) extLow = 1'b0;
            step(1);
            seen |= coreReset;
        end
        `CHK("short pin pulse", 1'b0, seen)
        n0 = nFetched;
        extLow = 1'b1;
        step(20);
        `CHK("pin reset", 1'b1, coreReset)
        extLow = 1'b0;
        waitFetch(n0);
        `CHK("pin reset vector", 16'hFFFE, lastVector)
        $display("test pin reset done");
        // Turn trap and watchdog into interrupts, then walk every source
        wdtCtrlTrapAction = 1'b0;
        wdtCtrlWdtAction = 1'b0;
        wdtCtrlWrite = 1'b1;
        step(1);
        for (int i = 0; i < 18; i++) begin
            level15SourceSelect = (i == 15);
            level16SourceSelect = (i == 17);
            fetchDelay = 4'(i % 5);
            eiStrobe = 1'b1;
            step(1);
            n0 = nFetched;
            fire(i);
            waitFetch(n0);
            `CHK("vector", rowVec[i], lastVector)
            `CHK("latch clear", 15'h0000, irqPendingLatch)
            `CHK("enable clear", 1'b0, masterIrqEnable)
            `CHK("enable stacked", 1'b1, stackedMasterEnable)
        end
        $display("test source table done");
        // Masking by master and by source enable
        fire(5);
        step(4);
        `CHK("latch set", 1'b1, irqPendingLatch[5])
        `CHK("masked by imf", 1'b0, irqRequest)
        sourceIrqEnable[5] = 1'b0;
        eiStrobe = 1'b1;
        step(4);
        `CHK("masked by enable", 1'b0, irqRequest)
        n0 = nFetched;
        sourceIrqEnable[5] = 1'b1;
        waitFetch(n0);
        `CHK("unmasked vector", 16'hFFF4, lastVector)
        // External 0 gate, latch clear, unselected shared source
        ext0IrqGate = 1'b0;
        eiStrobe = 1'b1;
        fire(4);
        step(4);
        `CHK("ext0 gate", 1'b0, irqRequest)
        latchClearMask = 14'h0004;
        latchClearStrobe = 1'b1;
        serialTxIrq = 1'b1;
        diStrobe = 1'b1;
        step(2);
        `CHK("cleared, dropped", 15'h0000, irqPendingLatch)
        ext0IrqGate = 1'b1;
        $display("test masking done");
        // Two pending together: higher priority first
        sourceIrq[9] = 1'b1;
        sourceIrq[6] = 1'b1;
        step(2);
        for (int j = 0; j < 2; j++) begin
            n0 = nFetched;
            eiStrobe = 1'b1;
            waitFetch(n0);
            `CHK("priority", j ? 16'hFFEC : 16'hFFF2, lastVector)
        end
        retiMasterEnable = 1'b1;
        retiStrobe = 1'b1;
        step(1);
        `CHK("return restores enable", 1'b1, masterIrqEnable)
        $display("test priority and return done");
        conclude();
    end
endmodule
`default_nettype wire
